/* File: src/mss_sample_sync.sv */
`timescale 1ns/1ns
//------------------------------------------------------------
// word fifo
//------------------------------------------------------------
module mss_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (fill != (AW+1)'(DEPTH));
  assign out_valid_out = (fill != '0);
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//------------------------------------------------------------
// sample timing and data set assembly
//------------------------------------------------------------
module mss_sample_sync #(
  parameter int SAMPLE_DIV = mss_pkg::SAMPLE_DIV_DEF,
  parameter int SYNC_CYC   = mss_pkg::SYNC_CYC_DEF
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [mss_pkg::REG_AW-1:0]  reg_addr_in,
  input  wire logic [mss_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic [mss_pkg::DATA_W-1:0]       reg_rdata_out,
  input  wire logic                        sync_pulse_in,
  input  wire logic [mss_pkg::NUM_SRC-1:0][mss_pkg::SAMPLE_W-1:0] src_sample_in,
  output logic                             sample_strobe_out,
  output mss_pkg::mss_word_type            stream_out,
  output logic                             stream_valid_out,
  input  wire logic                        stream_ready_in
);
  import mss_pkg::*;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic chan_hit(input logic [REG_AW-1:0] a);
    return (a >= OFF_CHAN) && (a < OFF_CHAN + REG_AW'(4 * NUM_CH)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] chan_index(input logic [REG_AW-1:0] a);
    logic [REG_AW-1:0] d;
    d = a - OFF_CHAN;
    return d[5:2];
  endfunction

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  logic                run;
  logic                sync_en;
  logic [7:0]          data_set_selector;
  logic [CFG_W-1:0]    chan_cfg [NUM_CH];
  logic                sync_locked;
  logic                overrun;
  logic                refused;
  logic [CNT_W-1:0]    set_count;
  logic [CNT_W-1:0]    head_count;
  logic [31:0]         phase_cnt;
  logic [31:0]         sec_cnt;
  logic                sync_prev;
  logic [SAMPLE_W-1:0] snap [NUM_CH];
  mss_state_type       state;
  mss_state_type       next_state;
  logic [3:0]          word_idx;
  logic [DATA_W-1:0]   next_rdata;

  //------------------------------------------------------------
  // register decode
  //------------------------------------------------------------
  wire wr_ctrl    = reg_wr_in && (reg_addr_in == OFF_CTRL);
  wire wr_sel     = reg_wr_in && (reg_addr_in == OFF_SELECTOR);
  wire wr_status  = reg_wr_in && (reg_addr_in == OFF_STATUS);
  wire wr_chan    = reg_wr_in && chan_hit(reg_addr_in);
  wire [3:0] widx = chan_index(reg_addr_in);
  wire sel_legal  = (reg_wdata_in[7:0] == SEL_STD) || (reg_wdata_in[7:0] == SEL_FREE);
  wire cfg_open   = !run;
  wire sel_take   = wr_sel && cfg_open && sel_legal;
  wire cfg_reject = (wr_sel && !(cfg_open && sel_legal)) || (wr_chan && !cfg_open);

  //------------------------------------------------------------
  // sample timing
  //------------------------------------------------------------
  wire sync_edge = sync_pulse_in && !sync_prev;
  wire sync_tick = run && sync_en && sync_edge;
  wire free_tick = run && (phase_cnt == 32'(SAMPLE_DIV - 1));
  wire tick      = sync_tick || free_tick;
  wire idle      = (state == ST_IDLE);
  wire take      = tick && idle;
  wire lock_ok   = (sec_cnt >= 32'(SYNC_CYC - SYNC_TOL_CYC - 1))
                && (sec_cnt <= 32'(SYNC_CYC + SYNC_TOL_CYC - 1));
  wire lock_lost = (sec_cnt > 32'(SYNC_CYC + SYNC_TOL_CYC - 1));

  assign sample_strobe_out = tick;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_prev <= 1'b0;
      phase_cnt <= '0;
    end else begin
      sync_prev <= sync_pulse_in;
      if (!run || tick) begin
        phase_cnt <= '0;
      end else begin
        phase_cnt <= phase_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sec_cnt     <= '0;
      sync_locked <= 1'b0;
    end else if (sync_edge) begin
      sec_cnt     <= '0;
      sync_locked <= lock_ok;
    end else begin
      sec_cnt     <= lock_lost ? sec_cnt : sec_cnt + 32'h1;
      sync_locked <= sync_locked && !lock_lost;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || !run) begin
      set_count  <= '0;
      head_count <= '0;
    end else if (tick) begin
      set_count  <= (sync_tick ? '0 : set_count) + CNT_W'(1);
      if (idle) begin
        head_count <= sync_tick ? '0 : set_count;
      end
    end
  end

  //------------------------------------------------------------
  // channel snapshot
  //------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
      wire [SRC_W-1:0] src_sel = (data_set_selector == SEL_FREE)
                               ? chan_cfg[gi][CFG_SRC_L +: SRC_W] : SRC_W'(gi);
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          snap[gi] <= '0;
        end else if (take) begin
          snap[gi] <= src_sample_in[src_sel];
        end
      end
    end
  endgenerate

  //------------------------------------------------------------
  // set assembly
  //------------------------------------------------------------
  mss_word_type fifo_word;
  logic         fifo_ready;
  wire          last_chan = (word_idx == 4'(NUM_CH - 1));
  wire          advance   = !idle && fifo_ready;

  assign fifo_word.data = (state == ST_HEAD) ? head_count
                        : (state == ST_INFO) ? {sync_locked, 7'h00, data_set_selector}
                        : snap[word_idx];
  assign fifo_word.last = (state == ST_CHAN) && last_chan;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (fifo_ready) begin
          next_state = ST_INFO;
        end
      end
      ST_INFO: begin
        if (fifo_ready) begin
          next_state = ST_CHAN;
        end
      end
      ST_CHAN: begin
        if (fifo_ready && last_chan) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state    <= ST_IDLE;
      word_idx <= '0;
    end else begin
      state <= next_state;
      if (state == ST_CHAN && advance) begin
        word_idx <= last_chan ? '0 : word_idx + 4'h1;
      end
    end
  end

  // stall on a full fifo stretches the set; a tick meanwhile is dropped
  mss_fifo #(
    .WIDTH ($bits(mss_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (fifo_word),
    .in_valid_in   (!idle),
    .in_ready_out  (fifo_ready),
    .out_data_out  (stream_out),
    .out_valid_out (stream_valid_out),
    .out_ready_in  (stream_ready_in)
  );

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      run               <= 1'b0;
      sync_en           <= 1'b0;
      data_set_selector <= SEL_STD;
    end else begin
      if (wr_ctrl) begin
        run     <= reg_wdata_in[BIT_RUN];
        sync_en <= reg_wdata_in[BIT_SYNC_EN];
      end
      if (sel_take) begin
        data_set_selector <= reg_wdata_in[7:0];
      end
    end
  end

  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_cfg
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          chan_cfg[gi] <= {protection_current_scale, REF_PHASE_I, SRC_W'(gi)};
        end else if (wr_chan && cfg_open && (widx == 4'(gi))) begin
          chan_cfg[gi] <= reg_wdata_in[CFG_W-1:0];
        end
      end
    end
  endgenerate

  // sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      overrun <= 1'b0;
      refused <= 1'b0;
    end else begin
      overrun <= (tick && !idle) || (overrun && !(wr_status && reg_wdata_in[BIT_OVERRUN]));
      refused <= cfg_reject || (refused && !(wr_status && reg_wdata_in[BIT_REFUSED]));
    end
  end

  always_comb begin
    next_rdata = '0;
    if (reg_addr_in == OFF_CTRL) begin
      next_rdata[BIT_RUN]     = run;
      next_rdata[BIT_SYNC_EN] = sync_en;
    end else if (reg_addr_in == OFF_SELECTOR) begin
      next_rdata[7:0] = data_set_selector;
    end else if (reg_addr_in == OFF_STATUS) begin
      next_rdata[BIT_LOCKED]  = sync_locked;
      next_rdata[BIT_OVERRUN] = overrun;
      next_rdata[BIT_REFUSED] = refused;
    end else if (reg_addr_in == OFF_SETCOUNT) begin
      next_rdata[CNT_W-1:0] = set_count;
    end else if (chan_hit(reg_addr_in)) begin
      next_rdata[CFG_W-1:0] = chan_cfg[widx];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? next_rdata : '0;
    end
  end
endmodule

/* File: src/mss_pkg.sv */
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
package mss_pkg;
  localparam int REG_AW   = 8;
  localparam int DATA_W   = 32;
  localparam int SAMPLE_W = 16;
  localparam int NUM_CH   = 12;
  localparam int NUM_SRC  = 16;
  localparam int SRC_W    = 4;
  localparam int CNT_W    = 16;
  localparam int FIFO_DEPTH = 32;

  // timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int DATA_RATE_HZ   = 4_000;
  localparam int SAMPLE_DIV_DEF = CLK_HZ / DATA_RATE_HZ;
  localparam int SYNC_PERIOD_S  = 1;
  localparam int SYNC_CYC_DEF   = CLK_HZ * SYNC_PERIOD_S;
  localparam int SYNC_TOL_NS    = 1_000;
  localparam int SYNC_TOL_CYC   = (SYNC_TOL_NS * (CLK_HZ / 1_000_000)) / 1_000;

  // register map
  localparam logic [REG_AW-1:0] OFF_CTRL     = 8'h00;
  localparam logic [REG_AW-1:0] OFF_SELECTOR = 8'h04;
  localparam logic [REG_AW-1:0] OFF_STATUS   = 8'h08;
  localparam logic [REG_AW-1:0] OFF_SETCOUNT = 8'h0C;
  localparam logic [REG_AW-1:0] OFF_CHAN     = 8'h10;
  localparam int BIT_RUN      = 0;
  localparam int BIT_SYNC_EN  = 1;
  localparam int BIT_LOCKED   = 0;
  localparam int BIT_OVERRUN  = 1;
  localparam int BIT_REFUSED  = 2;

  // data set selector codes
  localparam logic [7:0] SEL_STD  = 8'h01;
  localparam logic [7:0] SEL_FREE = 8'hFE;

  // channel descriptor: source [3:0], reference [5:4], scale [7:6]
  localparam int CFG_W     = 8;
  localparam int CFG_SRC_L = 0;
  localparam int CFG_REF_L = 4;
  localparam int CFG_SCL_L = 6;
  localparam logic [1:0] REF_PHASE_I   = 2'h0;
  localparam logic [1:0] REF_NEUTRAL_I = 2'h1;
  localparam logic [1:0] REF_PHASE_V   = 2'h2;
  localparam logic [1:0] protection_current_scale  = 2'h0;
  localparam logic [1:0] measurement_current_scale = 2'h1;
  localparam logic [1:0] voltage_scale             = 2'h2;

  typedef struct packed {
    logic                last;
    logic [SAMPLE_W-1:0] data;
  } mss_word_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_INFO = 2'b10,
    ST_CHAN = 2'b11
  } mss_state_type;
endpackage

/* File: verification/mss_sample_sync_props.sv */
`timescale 1ns/1ns
//--------
// checker
//--------
module mss_sample_sync_props import mss_pkg::*; #(
  parameter int SAMPLE_DIV = SAMPLE_DIV_DEF,
  parameter int SYNC_CYC   = SYNC_CYC_DEF
) (
  input wire logic                                               ref_clk_in,
  input wire logic                                               rst_n_in,
  input wire logic [mss_pkg::REG_AW-1:0]                         reg_addr_in,
  input wire logic [mss_pkg::DATA_W-1:0]                         reg_wdata_in,
  input wire logic                                               reg_wr_in,
  input wire logic                                               reg_rd_in,
  input wire logic [mss_pkg::DATA_W-1:0]                         reg_rdata_out,
  input wire logic                                               sync_pulse_in,
  input wire logic [mss_pkg::NUM_SRC-1:0][mss_pkg::SAMPLE_W-1:0] src_sample_in,
  input wire logic                                               sample_strobe_out,
  input wire mss_pkg::mss_word_type                              stream_out,
  input wire logic                                               stream_valid_out,
  input wire logic                                               stream_ready_in
);
  logic       sync_q;
  logic       seen;
  logic [1:0] ctrl;
  logic [3:0] wcnt;
  int         gap;
  wire        rise = sync_pulse_in & ~sync_q;
  wire        take = stream_valid_out & stream_ready_in;
  wire        sync_on = ctrl[BIT_RUN] & ctrl[BIT_SYNC_EN];
  // shadow of the control word, since only ports are visible
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_q <= 1'b0;
      ctrl   <= 2'h0;
      seen   <= 1'b0;
      gap    <= 0;
      wcnt   <= 4'h0;
    end else begin
      sync_q <= sync_pulse_in;
      if (reg_wr_in && reg_addr_in == OFF_CTRL) ctrl <= reg_wdata_in[1:0];
      seen   <= ctrl[BIT_RUN] & (seen | sample_strobe_out);
      gap    <= sample_strobe_out ? 1 : gap + 1;
      if (take) wcnt <= stream_out.last ? 4'h0 : wcnt + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_strobe_single: assert property (
    sample_strobe_out |=> !sample_strobe_out || rise) else $error("strobe too long");
  a_idle_no_tick: assert property (
    !ctrl[BIT_RUN] |-> !sample_strobe_out) else $error("tick while stopped");
  a_sync_same_cycle: assert property (
    rise && sync_on |-> sample_strobe_out) else $error("no tick at pulse edge");
  a_tick_interval: assert property (
    sample_strobe_out && seen && !(rise && sync_on) |-> gap == SAMPLE_DIV)
    else $error("tick spacing wrong");
  a_stream_hold: assert property (
    stream_valid_out && !stream_ready_in |=> stream_valid_out && $stable(stream_out))
    else $error("word changed while stalled");
  a_first_word: assert property (
    sample_strobe_out && !stream_valid_out |-> ##2 stream_valid_out)
    else $error("header late");
  a_set_length: assert property (
    take |-> stream_out.last == (wcnt == 4'hD)) else $error("set length wrong");
  a_header_zero: assert property (
    sample_strobe_out && rise && sync_on && !stream_valid_out
      |-> ##2 stream_valid_out && stream_out.data == '0) else $error("sync header not 0");
  c_sync_tick: cover property (sample_strobe_out && rise);
  c_set_end: cover property (take && stream_out.last);
  c_stall: cover property (stream_valid_out && !stream_ready_in);
endmodule

bind mss_sample_sync mss_sample_sync_props #(.SAMPLE_DIV(SAMPLE_DIV), .SYNC_CYC(SYNC_CYC))
  u_props (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .sync_pulse_in(sync_pulse_in),
  .src_sample_in(src_sample_in), .sample_strobe_out(sample_strobe_out),
  .stream_out(stream_out), .stream_valid_out(stream_valid_out),
  .stream_ready_in(stream_ready_in));

/* File: verification/mss_sink_model.sv */
`timescale 1ns/1ns
//------------
// stream sink
//------------
module mss_sink_model import mss_pkg::*; (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 stall_in,
  input  wire logic                 stream_valid_in,
  input  wire mss_pkg::mss_word_type stream_in,
  output logic                      ready_out,
  output logic                      got_out,
  output mss_pkg::mss_word_type     word_out
);
  integer seed = 77;
  // slow consumer: ready one cycle in four dropped, or held low on stall
  always @(posedge ref_clk_in) begin
    ready_out <= rst_n_in & !stall_in & ($random(seed) % 4 != 0);
  end
  assign got_out  = stream_valid_in & ready_out;
  assign word_out = stream_in;
endmodule

/* File: verification/mss_sample_sync_tb_top.sv */
`timescale 1ns/1ns
//-----------
// bench top
//-----------
module mss_sample_sync_tb_top;
  import mss_pkg::*;
  localparam int DIV = 40;
  logic ref_clk_in, rst_n_in, wr, rd, sync_p, sync_q, stall, rdy, got, strobe, svalid;
  logic [REG_AW-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [NUM_SRC-1:0][SAMPLE_W-1:0] src;
  mss_word_type sout, word;
  logic [7:0] sel;
  logic [CFG_W-1:0] cfg [NUM_CH];
  logic [32:0] expq [$];
  logic [32:0] e;
  int fail_count = 0;
  int n_checks = 0;
  int cnt = 0;
  int cyc = 0;
  int last_tick = 0;
  integer seed = 48;
  bit ignore = 0;
  mss_sample_sync #(.SAMPLE_DIV(DIV), .SYNC_CYC(200)) dut (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .sync_pulse_in(sync_p), .src_sample_in(src),
    .sample_strobe_out(strobe), .stream_out(sout), .stream_valid_out(svalid),
    .stream_ready_in(rdy));
  mss_sink_model sink (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .stall_in(stall),
    .stream_valid_in(svalid), .stream_in(sout), .ready_out(rdy), .got_out(got),
    .word_out(word));
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what,
                        input logic [31:0] m = '1);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(negedge ref_clk_in);
    check(what, rdata & m, exp);
    @(posedge ref_clk_in);
  endtask
  task automatic start_run(input logic [7:0] s);
    sel = s;
    wr_reg(OFF_SELECTOR, {24'h0, s});
    rd_reg(OFF_SELECTOR, {24'h0, s}, "selector");
    wr_reg(OFF_CTRL, 32'h3);
  endtask
  task automatic stop_run();
    wr_reg(OFF_CTRL, 32'h0);
    cnt = 0;
    // look between edges so the fill count has settled
    @(negedge ref_clk_in);
    for (int t = 0; t < 300 && svalid !== 1'b0; t++) @(negedge ref_clk_in);
    @(posedge ref_clk_in);
    check("drained", {31'h0, svalid}, 32'h0);
    if (!ignore) check("left over", expq.size(), 32'h0);
    expq.delete();
    ignore = 0;
  endtask
  task automatic pulse();
    sync_p <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    sync_p <= 1'b0;
  endtask
  //--------------------------------
  // expected sets from tick snapshot
  //--------------------------------
  always @(posedge ref_clk_in) begin
    sync_q <= sync_p;
    for (int i = 0; i < NUM_SRC; i++) src[i] <= SAMPLE_W'($random(seed));
    cyc++;
    if (strobe) begin
      if (sync_p && !sync_q) cnt = 0;
      else if (cnt != 0) check("tick spacing", 32'(cyc - last_tick), 32'(DIV));
      last_tick = cyc;
      expq.push_back({1'b0, 16'hFFFF, 16'(cnt)});
      // locked flag in the info word is timing dependent, so masked
      expq.push_back({1'b0, 16'h7FFF, 8'h00, sel});
      for (int k = 0; k < NUM_CH; k++)
        expq.push_back({k == NUM_CH - 1, 16'hFFFF, src[sel == SEL_FREE ? cfg[k][3:0] : k]});
      cnt++;
    end
    if (got && !ignore) begin
      check("word expected", {31'h0, expq.size() > 0}, 32'h1);
      e = (expq.size() > 0) ? expq.pop_front() : 33'h0;
      check("word", {15'h0, word.last, word.data & e[31:16]}, {15'h0, e[32], e[15:0]});
    end
  end
  initial begin
    rst_n_in = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    sync_p = 1'b0;
    sync_q = 1'b0;
    stall = 1'b0;
    src = '0;
    sel = SEL_STD;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_reg(OFF_SELECTOR, 32'h01, "selector reset");
    rd_reg(OFF_STATUS, 32'h0, "status reset", 32'h6);
    rd_reg(8'h40, 32'h0, "unmapped");
    for (int i = 0; i < NUM_CH; i++) rd_reg(OFF_CHAN + 8'(4 * i), 32'(i), "map reset");
    start_run(SEL_STD);
    repeat (6 * DIV + 20) @(posedge ref_clk_in);
    rd_reg(OFF_SETCOUNT, 32'd6, "set counter");
    stop_run();
    // unknown selector codes are refused even while stopped
    wr_reg(OFF_SELECTOR, 32'h02);
    rd_reg(OFF_SELECTOR, 32'h01, "odd selector");
    rd_reg(OFF_STATUS, 32'h4, "odd refused", 32'h4);
    wr_reg(OFF_STATUS, 32'h4);
    for (int i = 0; i < NUM_CH; i++) begin
      cfg[i] = {2'(i % 3), 2'(i / 4), 4'($random(seed))};
      wr_reg(OFF_CHAN + 8'(4 * i), {24'h0, cfg[i]});
      rd_reg(OFF_CHAN + 8'(4 * i), {24'h0, cfg[i]}, "map entry");
    end
    start_run(SEL_FREE);
    wr_reg(OFF_SELECTOR, 32'h01);
    wr_reg(OFF_CHAN, 32'h0F);
    rd_reg(OFF_SELECTOR, 32'hFE, "selector kept");
    rd_reg(OFF_CHAN, {24'h0, cfg[0]}, "map kept");
    rd_reg(OFF_STATUS, 32'h4, "refused", 32'h4);
    wr_reg(OFF_STATUS, 32'h4);
    rd_reg(OFF_STATUS, 32'h0, "refused clear", 32'h4);
    // pulses land 20 cycles past a tick so no set is mid-assembly
    for (int t = 0; t < 100 && strobe !== 1'b1; t++) @(negedge ref_clk_in);
    check("tick seen", {31'h0, strobe}, 32'h1);
    repeat (20) @(posedge ref_clk_in);
    pulse();
    repeat (4) begin
      repeat (217) @(posedge ref_clk_in);
      pulse();
    end
    rd_reg(OFF_STATUS, 32'h1, "locked", 32'h1);
    ignore = 1;
    stall <= 1'b1;
    repeat (5 * DIV) @(posedge ref_clk_in);
    rd_reg(OFF_STATUS, 32'h2, "overrun", 32'h2);
    stall <= 1'b0;
    stop_run();
    wr_reg(OFF_STATUS, 32'h2);
    rd_reg(OFF_STATUS, 32'h0, "overrun clear", 32'h2);
    report_and_stop();
  end
  initial begin
    #(40 * 20000);
    fail_count++;
    report_and_stop();
  end
endmodule
